// ==== dv/mcu_reset_source_control_chk.sv ====
// Assertions for the reset source controller, bound to its top ports.
// Assumes every port is sampled on REF_CLK_IN; RESET_IN is power-on.
`timescale 1ns/1ns
`include "reset_ctrl_defs.vh"

module reset_ctrl_chk (
  input wire REF_CLK_IN,
  input wire RESET_IN,
  input wire EXT_RESET_PIN_N_IN,
  input wire PIN_IS_RESET_OPT_IN,
  input wire LOWVOLT_ENABLE_OPT_IN,
  input wire [1:0] LOWVOLT_THRESHOLD_OPT_IN,
  input wire SUPPLY_LOW_IN,
  input wire WATCHDOG_OVERFLOW_IN,
  input wire HALTED_IN,
  input wire [1:0] LOWVOLT_THRESHOLD_OUT,
  input wire PORT_A_BIT7_IN_OUT,
  input wire CORE_RUN_OUT,
  input wire [2:0] RESET_CAUSE_OUT,
  input wire [11:0] PROGCOUNT_OUT,
  input wire [2:0] STACK_PTR_OUT,
  input wire WATCHDOG_TIMEOUT_FLAG_OUT,
  input wire POWERDOWN_FLAG_OUT,
  input wire WATCHDOG_CLEAR_OUT,
  input wire PRESERVE_ACC_TABLE_OUT,
  input wire RESET_EVENT_OUT
);
  // ----------------------------------------
  // Helper: length of the current low-supply episode
  // ----------------------------------------
  reg [15:0] low_cnt_q; // Counts only while the detector is enabled
  wire [15:0] low_cnt_d = (SUPPLY_LOW_IN && LOWVOLT_ENABLE_OPT_IN) ? low_cnt_q + 16'h0001 : 16'h0000;
  wire hold_ev = RESET_EVENT_OUT && (RESET_CAUSE_OUT == `CAUSE_PIN || RESET_CAUSE_OUT == `CAUSE_LVR);
  // Counter restarts on every high sample, so a dip shorter than the window never reaches it
  always @(posedge REF_CLK_IN) begin
    low_cnt_q <= RESET_IN ? 16'h0000 : low_cnt_d;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  por_cold_a: assert property ($fell(RESET_IN) |-> RESET_CAUSE_OUT == `CAUSE_POR && !CORE_RUN_OUT
    && !WATCHDOG_TIMEOUT_FLAG_OUT && !POWERDOWN_FLAG_OUT && !PRESERVE_ACC_TABLE_OUT && WATCHDOG_CLEAR_OUT)
    else $error("cold state missing after power-on");
  wdt_run_a: assert property (WATCHDOG_OVERFLOW_IN && !HALTED_IN && CORE_RUN_OUT && !SUPPLY_LOW_IN
    |-> ##[1:2] RESET_EVENT_OUT && RESET_CAUSE_OUT == `CAUSE_WDT_RUN && WATCHDOG_TIMEOUT_FLAG_OUT)
    else $error("watchdog run reset not applied");
  wdt_halt_a: assert property (WATCHDOG_OVERFLOW_IN && HALTED_IN && CORE_RUN_OUT && !SUPPLY_LOW_IN
    |-> ##[1:2] RESET_CAUSE_OUT == `CAUSE_WDT_HALT && WATCHDOG_TIMEOUT_FLAG_OUT && POWERDOWN_FLAG_OUT
    && PROGCOUNT_OUT == 12'h000 && STACK_PTR_OUT == 3'h0) else $error("watchdog halt reset not applied");
  hold_core_a: assert property (hold_ev |=> !CORE_RUN_OUT [*2])
    else $error("core runs during pin or supply reset");
  hold_flags_a: assert property (hold_ev |-> !WATCHDOG_TIMEOUT_FLAG_OUT && !POWERDOWN_FLAG_OUT
    && WATCHDOG_CLEAR_OUT && PROGCOUNT_OUT == 12'h000) else $error("pin or supply reset flags wrong");
  pin_port_a: assert property ((!PIN_IS_RESET_OPT_IN && $stable(EXT_RESET_PIN_N_IN)) [*4]
    |-> PORT_A_BIT7_IN_OUT == EXT_RESET_PIN_N_IN && !(RESET_EVENT_OUT && RESET_CAUSE_OUT == `CAUSE_PIN))
    else $error("port bit not following pin");
  pin_opt_a: assert property (PIN_IS_RESET_OPT_IN [*4] |-> PORT_A_BIT7_IN_OUT)
    else $error("port bit not parked high");
  lvr_qual_a: assert property ($rose(RESET_EVENT_OUT) && RESET_CAUSE_OUT == `CAUSE_LVR
    |-> low_cnt_q >= `LVQ_CYCLES) else $error("supply reset before qualification");
  thresh_a: assert property (!$past(RESET_IN) |-> LOWVOLT_THRESHOLD_OUT == $past(LOWVOLT_THRESHOLD_OPT_IN))
    else $error("threshold option not passed on");
  keep_a: assert property (RESET_EVENT_OUT && RESET_CAUSE_OUT != `CAUSE_POR |-> PRESERVE_ACC_TABLE_OUT)
    else $error("working registers not kept");
  // Main scenarios reached
  pin_c: cover property (RESET_EVENT_OUT && RESET_CAUSE_OUT == `CAUSE_PIN);
  lvr_c: cover property (RESET_EVENT_OUT && RESET_CAUSE_OUT == `CAUSE_LVR);
  halt_c: cover property (RESET_EVENT_OUT && RESET_CAUSE_OUT == `CAUSE_WDT_HALT);
endmodule

bind mcu_reset_source_control reset_ctrl_chk u_chk (
  .REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .EXT_RESET_PIN_N_IN(EXT_RESET_PIN_N_IN),
  .PIN_IS_RESET_OPT_IN(PIN_IS_RESET_OPT_IN), .LOWVOLT_ENABLE_OPT_IN(LOWVOLT_ENABLE_OPT_IN),
  .LOWVOLT_THRESHOLD_OPT_IN(LOWVOLT_THRESHOLD_OPT_IN), .SUPPLY_LOW_IN(SUPPLY_LOW_IN),
  .WATCHDOG_OVERFLOW_IN(WATCHDOG_OVERFLOW_IN), .HALTED_IN(HALTED_IN), .LOWVOLT_THRESHOLD_OUT(LOWVOLT_THRESHOLD_OUT),
  .PORT_A_BIT7_IN_OUT(PORT_A_BIT7_IN_OUT), .CORE_RUN_OUT(CORE_RUN_OUT), .RESET_CAUSE_OUT(RESET_CAUSE_OUT),
  .PROGCOUNT_OUT(PROGCOUNT_OUT), .STACK_PTR_OUT(STACK_PTR_OUT), .WATCHDOG_TIMEOUT_FLAG_OUT(WATCHDOG_TIMEOUT_FLAG_OUT),
  .POWERDOWN_FLAG_OUT(POWERDOWN_FLAG_OUT), .WATCHDOG_CLEAR_OUT(WATCHDOG_CLEAR_OUT),
  .PRESERVE_ACC_TABLE_OUT(PRESERVE_ACC_TABLE_OUT), .RESET_EVENT_OUT(RESET_EVENT_OUT)
);

// ==== dv/reset_switch_model.sv ====
// External reset switch with a pull-up on the shared reset pin.
// Assumes the bench closes the switch off the sampling clock edge.
`timescale 1ns/1ns

module reset_switch_model (
  input wire press_in, // Switch closed
  output wire pin_n_out // Pin level seen by the device
);
  // Closed switch grounds the pin; open, the pull-up wins, so the pin never floats
  assign pin_n_out = press_in ? 1'b0 : 1'b1;
endmodule

// ==== dv/test_mcu_reset_source_control.sv ====
// Self-checking bench for the reset source controller.
// Assumes the switch model on the pin; clock and reset are made here.
`timescale 1ns/1ns
`include "reset_ctrl_defs.vh"

module test_mcu_reset_source_control;
  // ----------------------------------------
  // Stimulus, observed outputs, notes
  // ----------------------------------------
  reg clk = 1'b0; // 100 MHz system clock
  reg rst = 1'b1; // Power-on reset
  reg press = 1'b0, opt_pin = 1'b1, lv_en = 1'b0, sup_low = 1'b0; // Pin and supply
  reg wdt_ov = 1'b0, usb_rst = 1'b0, halted = 1'b0, set_pd = 1'b0, clr_fl = 1'b0; // Core events
  reg [1:0] lv_thr = 2'h0; // Threshold option
  wire pin_n, bit7, run, to_f, pdf_f, wclr, pclr, keep, ev;
  wire [1:0] thr_o;
  wire [2:0] cause, sp, watchdog_prescale_select;
  wire [11:0] pc;
  wire [4:0] timer_control;
  wire [5:0] dl;
  wire [7:0] intc, progcount_low_byte, dh, base, pa_d, pa_c, pb_d, pb_c, pc_d, pc_c;
  reg [5:0] exp_q[$]; // Notes: cause, timeout, powerdown, keep
  reg [5:0] note;
  reg to_m = 1'b0, pdf_m = 1'b0, ev_prev = 1'b1; // Flag model, event edge
  integer errors = 0, num_checks = 0, seed = 32'hd8c1, n, k;
  // Presets never differ from cold values: kept fields were cold already
  wire presets_ok = {pc, sp, progcount_low_byte, intc, dl, dh, base, watchdog_prescale_select, timer_control, pa_d, pa_c, pb_d, pb_c, pc_d, pc_c}
    === {12'h000, 3'h0, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 3'h7, 5'h01, {6{8'hff}}};

  mcu_reset_source_control u_dut (
    .REF_CLK_IN(clk), .RESET_IN(rst), .EXT_RESET_PIN_N_IN(pin_n), .PIN_IS_RESET_OPT_IN(opt_pin),
    .LOWVOLT_ENABLE_OPT_IN(lv_en), .LOWVOLT_THRESHOLD_OPT_IN(lv_thr), .SUPPLY_LOW_IN(sup_low),
    .WATCHDOG_OVERFLOW_IN(wdt_ov), .USB_RESET_IN(usb_rst), .HALTED_IN(halted), .SET_POWERDOWN_IN(set_pd),
    .CLEAR_FLAGS_IN(clr_fl), .LOWVOLT_THRESHOLD_OUT(thr_o), .PORT_A_BIT7_IN_OUT(bit7), .CORE_RUN_OUT(run),
    .RESET_CAUSE_OUT(cause), .PROGCOUNT_OUT(pc), .STACK_PTR_OUT(sp), .WATCHDOG_TIMEOUT_FLAG_OUT(to_f),
    .POWERDOWN_FLAG_OUT(pdf_f), .WATCHDOG_CLEAR_OUT(wclr), .PRESCALER_CLEAR_OUT(pclr),
    .WATCHDOG_PRESCALE_SELECT_OUT(watchdog_prescale_select), .INTERRUPT_CONTROL0_OUT(intc), .TIMER_CONTROL_OUT(timer_control),
    .PROGCOUNT_LOW_BYTE_OUT(progcount_low_byte), .PWM_CH0_DUTY_LOW_OUT(dl), .PWM_CH0_DUTY_HIGH_OUT(dh), .PWM_CH0_BASE_OUT(base),
    .PORT_A_DATA_OUT(pa_d), .PORT_A_DIRECTION_OUT(pa_c), .PORT_B_DATA_OUT(pb_d), .PORT_B_DIRECTION_OUT(pb_c),
    .PORT_C_DATA_OUT(pc_d), .PORT_C_DIRECTION_OUT(pc_c), .PRESERVE_ACC_TABLE_OUT(keep), .RESET_EVENT_OUT(ev)
  );
  reset_switch_model u_switch (.press_in(press), .pin_n_out(pin_n));

  always #5 clk = ~clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task bad(input [8*28:1] msg);
    begin
      errors = errors + 1;
      $display("unexpected at %0t: %0s", $time, msg);
    end
  endtask
  // Note one reset event and advance the flag model as its cause demands
  task note_ev(input [2:0] c);
    begin
      if (c == `CAUSE_PIN || c == `CAUSE_LVR || c == `CAUSE_USB_HALT) to_m = 1'b0;
      if (c == `CAUSE_PIN || c == `CAUSE_LVR) pdf_m = 1'b0;
      if (c == `CAUSE_WDT_RUN || c == `CAUSE_WDT_HALT) to_m = 1'b1;
      if (c == `CAUSE_WDT_HALT || c == `CAUSE_USB_HALT) pdf_m = 1'b1;
      exp_q.push_back({c, to_m, pdf_m, 1'b1});
    end
  endtask
  // One-cycle pulse on a core event line, then a random idle gap
  task fire(input integer w);
    begin
      if (w == 0) wdt_ov = 1'b1;
      else if (w == 1) usb_rst = 1'b1;
      else if (w == 2) set_pd = 1'b1;
      else clr_fl = 1'b1;
      @(negedge clk);
      {wdt_ov, usb_rst, set_pd, clr_fl} = 4'h0;
      repeat (2 + ($random(seed) & 3)) @(negedge clk);
    end
  endtask
  // Bounded wait for the core to be let run; too early also counts
  task wait_run;
    begin
      n = 0;
      while (run !== 1'b1 && n < 1500) begin
        @(negedge clk);
        n = n + 1;
      end
      num_checks = num_checks + 1;
      if (run !== 1'b1 || n < `SST_CYCLES) bad("start-up hold-off wrong");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Monitor: each rising event takes the oldest note
  // ----------------------------------------
  always @(negedge clk) begin
    if (!rst && ev === 1'b1 && ev_prev !== 1'b1) begin
      num_checks = num_checks + 1;
      if (exp_q.size() == 0) bad("reset event with no cause");
      else begin
        note = exp_q.pop_front();
        if ({cause, to_f, pdf_f, keep} !== note) bad("cause or flags wrong");
        if (!presets_ok) bad("presets wrong");
      end
    end
    ev_prev = ev;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    num_checks = num_checks + 1;
    if (!presets_ok || cause !== `CAUSE_POR || {keep, run, pclr, wclr} !== 4'h3) bad("cold state");
    rst = 1'b0;
    wait_run;
    for (k = 0; k < 8; k = k + 1) begin
      lv_thr = $random(seed);
      @(negedge clk);
      num_checks = num_checks + 1;
      if (thr_o !== lv_thr) bad("threshold copy");
    end
    fire(2);
    pdf_m = 1'b1;
    note_ev(`CAUSE_WDT_RUN);
    usb_rst = 1'b1;
    fire(0);
    halted = 1'b1;
    note_ev(`CAUSE_WDT_HALT);
    fire(0);
    note_ev(`CAUSE_USB_HALT);
    fire(1);
    halted = 1'b0;
    note_ev(`CAUSE_USB_RUN);
    fire(1);
    fire(3);
    num_checks = num_checks + 1;
    if ({to_f, pdf_f, run} !== 3'h1) bad("flag clear or core stopped");
    {to_m, pdf_m} = 2'h0;
    note_ev(`CAUSE_PIN);
    press = 1'b1;
    repeat (20) @(negedge clk);
    num_checks = num_checks + 1;
    if ({run, wclr, pclr} !== 3'h3) bad("pin hold");
    press = 1'b0;
    wait_run;
    opt_pin = 1'b0;
    press = 1'b1;
    repeat (6) @(negedge clk);
    num_checks = num_checks + 1;
    if ({bit7, run} !== 2'h1) bad("pin as port bit low");
    press = 1'b0;
    repeat (6) @(negedge clk);
    num_checks = num_checks + 1;
    if (bit7 !== 1'b1) bad("pin as port bit high");
    opt_pin = 1'b1;
    lv_en = 1'b1;
    for (k = 0; k < 3; k = k + 1) begin
      if (k == 1) note_ev(`CAUSE_LVR);
      if (k == 2) lv_en = 1'b0;
      sup_low = 1'b1;
      repeat (k == 0 ? 60 : 150) @(negedge clk);
      sup_low = 1'b0;
      if (k == 1) wait_run;
      else repeat (8) @(negedge clk);
    end
    num_checks = num_checks + 1;
    if (exp_q.size() != 0 || run !== 1'b1) bad("missing reset event");
    print_verdict;
  end

  // Cuts a hang short well beyond the planned run of some 3500 cycles
  initial begin
    #200000;
    bad("run did not finish");
    print_verdict;
  end
endmodule

// ==== hdl/lowvolt_qualify.v ====
// Qualifies the low-supply indication: a request only after it persists.
// Assumes the indication is synchronous to the system clock.
`timescale 1ns/1ns
`include "reset_ctrl_defs.vh"

module lowvolt_qualify (
  input wire clk_in, // System clock
  input wire rst_in, // Synchronous reset, active high
  input wire enable_in, // Detector enabled by option
  input wire low_in, // Low supply indication
  output reg fire_out // Qualified request, level
);

  reg [`CNT_W-1:0] cnt_q; // Persistence counter

  // ----------------------------------------
  // Persistence count
  // ----------------------------------------
  // Short dips restart the count, so glitches never reset the core
  always @(posedge clk_in) begin
    if (rst_in || !enable_in || !low_in) begin
      cnt_q <= `CNT_ZERO;
      fire_out <= `ONE_BIT_CLR;
    end else if (cnt_q < `LVQ_CYCLES) begin
      cnt_q <= cnt_q + `CNT_ONE;
      fire_out <= `ONE_BIT_CLR;
    end else begin
      fire_out <= `ONE_BIT_SET;
    end
  end

endmodule

// ==== hdl/mcu_reset_source_control.v ====
// Reset source controller of a small 8-bit core: takes pin, low-voltage,
// watchdog and bus-reset requests and drives per-cause register presets.
// Assumes inputs other than the pin and supply-low are synchronous to REF_CLK_IN; RESET_IN is power-on.
// ----------------------------------------
// Behaviour notes
// ----------------------------------------
// Pin and supply requests are levels. While either stands, the
// presets are reapplied every cycle and the core is held stopped.
// Only the first cycle of a pin request raises the event pulse.
// A qualified supply request raises it on every cycle it persists.
// Either way the monitor sees one rising edge per episode.
//
// Watchdog and bus requests are single-cycle events. They move the
// presets once and never stop the core: the core is assumed to
// restart from the new program counter by itself.
//
// Priority is pin, then supply, then watchdog, then bus reset.
// A lower request in the same cycle as a higher one is dropped, not
// queued. A watchdog overflow hidden under a pin reset is lost, which
// is harmless because the pin reset is the stronger of the two.
//
// The two status flags have three writers: the core's clear, the
// core's halt and the reset causes. A reset cause wins over both
// core writes. Set wins over clear when the core does both at once.
//
// The start-up hold-off restarts whenever a level request returns.
// Repeated dips on the pin therefore stretch the stopped time.
//
// The threshold option is only copied through a register. Nothing
// in the core can write it, so software cannot move the trip level.
//
// Accumulator and table contents are not held here. The preserve
// output only tells the core whether the old contents stay valid.
// After power-on they are undefined and software must not use them.
//
// Limitation: the shared pin is sampled by the system clock. A pulse
// shorter than one clock period may be missed altogether.
`timescale 1ns/1ns
`include "reset_ctrl_defs.vh"

module mcu_reset_source_control (
  input wire REF_CLK_IN, // 100 MHz system clock
  input wire RESET_IN, // Power-on reset, synchronous, active high
  input wire EXT_RESET_PIN_N_IN, // Shared pin level, active low reset
  input wire PIN_IS_RESET_OPT_IN, // Option: shared pin used as reset
  input wire LOWVOLT_ENABLE_OPT_IN, // Option: low-voltage reset on
  input wire [1:0] LOWVOLT_THRESHOLD_OPT_IN, // Option: threshold level select
  input wire SUPPLY_LOW_IN, // Analog indication, supply below threshold
  input wire WATCHDOG_OVERFLOW_IN, // Watchdog overflow pulse
  input wire USB_RESET_IN, // Bus reset request pulse
  input wire HALTED_IN, // Core is in power-down
  input wire SET_POWERDOWN_IN, // Core executed halt: set flag
  input wire CLEAR_FLAGS_IN, // Core clears both flags
  output reg [1:0] LOWVOLT_THRESHOLD_OUT, // Threshold to analog detector
  output reg PORT_A_BIT7_IN_OUT, // Shared pin seen as port bit
  output reg CORE_RUN_OUT, // Core may fetch instructions
  output reg [2:0] RESET_CAUSE_OUT, // Last reset cause code
  output reg [11:0] PROGCOUNT_OUT, // Program counter preset
  output reg [2:0] STACK_PTR_OUT, // Stack pointer preset
  output reg WATCHDOG_TIMEOUT_FLAG_OUT, // Status word timeout bit
  output reg POWERDOWN_FLAG_OUT, // Status word powerdown bit
  output reg WATCHDOG_CLEAR_OUT, // Clear and restart watchdog
  output reg PRESCALER_CLEAR_OUT, // Clear timer prescaler
  output reg [2:0] WATCHDOG_PRESCALE_SELECT_OUT, // Prescale select value
  output reg [7:0] INTERRUPT_CONTROL0_OUT, // Interrupt control preset
  output reg [4:0] TIMER_CONTROL_OUT, // Timer control preset
  output reg [7:0] PROGCOUNT_LOW_BYTE_OUT, // PC low byte preset
  output reg [5:0] PWM_CH0_DUTY_LOW_OUT, // PWM0 duty low preset
  output reg [7:0] PWM_CH0_DUTY_HIGH_OUT, // PWM0 duty high preset
  output reg [7:0] PWM_CH0_BASE_OUT, // PWM0 base preset
  output reg [7:0] PORT_A_DATA_OUT, // Port A data preset
  output reg [7:0] PORT_A_DIRECTION_OUT, // Port A direction preset
  output reg [7:0] PORT_B_DATA_OUT, // Port B data preset
  output reg [7:0] PORT_B_DIRECTION_OUT, // Port B direction preset
  output reg [7:0] PORT_C_DATA_OUT, // Port C data preset
  output reg [7:0] PORT_C_DIRECTION_OUT, // Port C direction preset
  output reg PRESERVE_ACC_TABLE_OUT, // Accumulator, table regs kept
  output reg RESET_EVENT_OUT // Pulse when presets apply; stays high while a supply reset persists
);

  // ----------------------------------------
  // Request conditioning
  // ----------------------------------------
  reg pin_s1_q; // Pin synchroniser first stage
  reg pin_s2_q; // Pin synchroniser second stage
  reg lv_s1_q; // Supply-low first stage
  reg lv_s2_q; // Supply-low second stage
  wire lv_fire; // Qualified low-voltage request
  wire run_ok; // Start-up delay elapsed
  reg hold_q; // Some source holds reset
  reg [2:0] cause_d; // Highest-priority cause this cycle
  reg pin_req; // Pin reset requested
  reg pin_req_q; // Pin request last cycle

  // Two-flop synchronisers; first stage feeds only the second
  always @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      pin_s1_q <= `ONE_BIT_SET;
      pin_s2_q <= `ONE_BIT_SET;
      lv_s1_q <= `ONE_BIT_CLR;
      lv_s2_q <= `ONE_BIT_CLR;
    end else begin
      pin_s1_q <= EXT_RESET_PIN_N_IN;
      pin_s2_q <= pin_s1_q;
      lv_s1_q <= SUPPLY_LOW_IN;
      lv_s2_q <= lv_s1_q;
    end
  end

  // Low-supply persistence filter
  lowvolt_qualify u_lvq (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .enable_in(LOWVOLT_ENABLE_OPT_IN),
    .low_in(lv_s2_q),
    .fire_out(lv_fire)
  );

  // Pin only counts as reset when optioned for it
  always @* begin
    pin_req = PIN_IS_RESET_OPT_IN && !pin_s2_q;
  end

  // Priority: pin, then low voltage, then watchdog, then bus reset
  always @* begin
    if (pin_req) begin
      cause_d = `CAUSE_PIN;
    end else if (lv_fire) begin
      cause_d = `CAUSE_LVR;
    end else if (WATCHDOG_OVERFLOW_IN) begin
      cause_d = HALTED_IN ? `CAUSE_WDT_HALT : `CAUSE_WDT_RUN;
    end else if (USB_RESET_IN) begin
      cause_d = HALTED_IN ? `CAUSE_USB_HALT : `CAUSE_USB_RUN;
    end else begin
      cause_d = `CAUSE_NONE;
    end
  end

  // Level hold: pin and LOW_VOLTAGE_RESET last while asserted
  always @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      hold_q <= `ONE_BIT_SET;
      pin_req_q <= `ONE_BIT_CLR;
    end else begin
      hold_q <= pin_req || lv_fire;
      pin_req_q <= pin_req;
    end
  end

  // Hold-off after power-on or pin/LOW_VOLTAGE_RESET release
  startup_delay u_sst (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .hold_in(hold_q),
    .run_out(run_ok)
  );

  // ----------------------------------------
  // Preset outputs
  // ----------------------------------------
  // Threshold is a straight copy of the option; no register writes it
  always @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      LOWVOLT_THRESHOLD_OUT <= `THR_RST;
      PORT_A_BIT7_IN_OUT <= `ONE_BIT_SET;
      CORE_RUN_OUT <= `ONE_BIT_CLR;
    end else begin
      LOWVOLT_THRESHOLD_OUT <= LOWVOLT_THRESHOLD_OPT_IN;
      PORT_A_BIT7_IN_OUT <= PIN_IS_RESET_OPT_IN ? `ONE_BIT_SET : pin_s2_q;
      CORE_RUN_OUT <= run_ok && !pin_req && !lv_fire;
    end
  end

  // Main preset register: power-on loads every cold value
  always @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      RESET_CAUSE_OUT <= `CAUSE_POR;
      PROGCOUNT_OUT <= `PC_ZERO;
      STACK_PTR_OUT <= `SP_EMPTY;
      WATCHDOG_TIMEOUT_FLAG_OUT <= `ONE_BIT_CLR;
      POWERDOWN_FLAG_OUT <= `ONE_BIT_CLR;
      WATCHDOG_CLEAR_OUT <= `ONE_BIT_SET;
      PRESCALER_CLEAR_OUT <= `ONE_BIT_SET;
      WATCHDOG_PRESCALE_SELECT_OUT <= `WATCHDOG_PRESCALE_SELECT_RST;
      INTERRUPT_CONTROL0_OUT <= `BYTE_ZERO;
      TIMER_CONTROL_OUT <= `TIMER_CONTROL_RST;
      PROGCOUNT_LOW_BYTE_OUT <= `BYTE_ZERO;
      PWM_CH0_DUTY_LOW_OUT <= `PWM_LOW_ZERO;
      PWM_CH0_DUTY_HIGH_OUT <= `BYTE_ZERO;
      PWM_CH0_BASE_OUT <= `BYTE_ZERO;
      PORT_A_DATA_OUT <= `BYTE_ONES;
      PORT_A_DIRECTION_OUT <= `BYTE_ONES;
      PORT_B_DATA_OUT <= `BYTE_ONES;
      PORT_B_DIRECTION_OUT <= `BYTE_ONES;
      PORT_C_DATA_OUT <= `BYTE_ONES;
      PORT_C_DIRECTION_OUT <= `BYTE_ONES;
      PRESERVE_ACC_TABLE_OUT <= `ONE_BIT_CLR;
      RESET_EVENT_OUT <= `ONE_BIT_SET;
    end else begin
      // Default: pulses drop, presets hold
      WATCHDOG_CLEAR_OUT <= `ONE_BIT_CLR;
      PRESCALER_CLEAR_OUT <= `ONE_BIT_CLR;
      RESET_EVENT_OUT <= `ONE_BIT_CLR;
      // Flag updates from the core; reset causes below win over them
      if (CLEAR_FLAGS_IN) begin
        WATCHDOG_TIMEOUT_FLAG_OUT <= `ONE_BIT_CLR;
        POWERDOWN_FLAG_OUT <= `ONE_BIT_CLR;
      end
      if (SET_POWERDOWN_IN) begin
        POWERDOWN_FLAG_OUT <= `ONE_BIT_SET;
      end
      case (cause_d)
        `CAUSE_PIN, `CAUSE_LVR: begin
          // Full warm reset; pin fires once per assertion edge, supply every cycle, held through level
          if (!(pin_req_q && cause_d == `CAUSE_PIN)) begin
            RESET_EVENT_OUT <= `ONE_BIT_SET;
          end
          RESET_CAUSE_OUT <= cause_d;
          PROGCOUNT_OUT <= `PC_ZERO;
          STACK_PTR_OUT <= `SP_EMPTY;
          WATCHDOG_TIMEOUT_FLAG_OUT <= `ONE_BIT_CLR;
          POWERDOWN_FLAG_OUT <= `ONE_BIT_CLR;
          WATCHDOG_CLEAR_OUT <= `ONE_BIT_SET;
          PRESCALER_CLEAR_OUT <= `ONE_BIT_SET;
          WATCHDOG_PRESCALE_SELECT_OUT <= `WATCHDOG_PRESCALE_SELECT_RST;
          INTERRUPT_CONTROL0_OUT <= `BYTE_ZERO;
          TIMER_CONTROL_OUT <= `TIMER_CONTROL_RST;
          PROGCOUNT_LOW_BYTE_OUT <= `BYTE_ZERO;
          PWM_CH0_DUTY_LOW_OUT <= `PWM_LOW_ZERO;
          PWM_CH0_DUTY_HIGH_OUT <= `BYTE_ZERO;
          PWM_CH0_BASE_OUT <= `BYTE_ZERO;
          PORT_A_DATA_OUT <= `BYTE_ONES;
          PORT_A_DIRECTION_OUT <= `BYTE_ONES;
          PORT_B_DATA_OUT <= `BYTE_ONES;
          PORT_B_DIRECTION_OUT <= `BYTE_ONES;
          PORT_C_DATA_OUT <= `BYTE_ONES;
          PORT_C_DIRECTION_OUT <= `BYTE_ONES;
          PRESERVE_ACC_TABLE_OUT <= `ONE_BIT_SET;
        end
        `CAUSE_WDT_RUN: begin
          // Same as pin reset, but timeout set and powerdown kept
          RESET_EVENT_OUT <= `ONE_BIT_SET;
          RESET_CAUSE_OUT <= cause_d;
          PROGCOUNT_OUT <= `PC_ZERO;
          STACK_PTR_OUT <= `SP_EMPTY;
          WATCHDOG_TIMEOUT_FLAG_OUT <= `ONE_BIT_SET;
          WATCHDOG_CLEAR_OUT <= `ONE_BIT_SET;
          PRESCALER_CLEAR_OUT <= `ONE_BIT_SET;
          WATCHDOG_PRESCALE_SELECT_OUT <= `WATCHDOG_PRESCALE_SELECT_RST;
          INTERRUPT_CONTROL0_OUT <= `BYTE_ZERO;
          TIMER_CONTROL_OUT <= `TIMER_CONTROL_RST;
          PROGCOUNT_LOW_BYTE_OUT <= `BYTE_ZERO;
          PWM_CH0_DUTY_LOW_OUT <= `PWM_LOW_ZERO;
          PWM_CH0_DUTY_HIGH_OUT <= `BYTE_ZERO;
          PWM_CH0_BASE_OUT <= `BYTE_ZERO;
          PORT_A_DATA_OUT <= `BYTE_ONES;
          PORT_A_DIRECTION_OUT <= `BYTE_ONES;
          PORT_B_DATA_OUT <= `BYTE_ONES;
          PORT_B_DIRECTION_OUT <= `BYTE_ONES;
          PORT_C_DATA_OUT <= `BYTE_ONES;
          PORT_C_DIRECTION_OUT <= `BYTE_ONES;
          PRESERVE_ACC_TABLE_OUT <= `ONE_BIT_SET;
        end
        `CAUSE_WDT_HALT: begin
          // Warm wake: only PC, PC low byte, SP, flags, prescale select and the preserve bit move; the rest stays put
          RESET_EVENT_OUT <= `ONE_BIT_SET;
          RESET_CAUSE_OUT <= cause_d;
          PROGCOUNT_OUT <= `PC_ZERO;
          STACK_PTR_OUT <= `SP_EMPTY;
          PROGCOUNT_LOW_BYTE_OUT <= `BYTE_ZERO;
          WATCHDOG_TIMEOUT_FLAG_OUT <= `ONE_BIT_SET;
          POWERDOWN_FLAG_OUT <= `ONE_BIT_SET;
          WATCHDOG_PRESCALE_SELECT_OUT <= `WATCHDOG_PRESCALE_SELECT_RST;
          PRESERVE_ACC_TABLE_OUT <= `ONE_BIT_SET;
        end
        `CAUSE_USB_RUN, `CAUSE_USB_HALT: begin
          // Bus reset: ports and PWM preset, timer control kept; flags kept unless halted
          RESET_EVENT_OUT <= `ONE_BIT_SET;
          RESET_CAUSE_OUT <= cause_d;
          PROGCOUNT_OUT <= `PC_ZERO;
          STACK_PTR_OUT <= `SP_EMPTY;
          if (cause_d == `CAUSE_USB_HALT) begin
            WATCHDOG_TIMEOUT_FLAG_OUT <= `ONE_BIT_CLR;
            POWERDOWN_FLAG_OUT <= `ONE_BIT_SET;
          end else begin
            WATCHDOG_PRESCALE_SELECT_OUT <= `WATCHDOG_PRESCALE_SELECT_RST;
          end
          INTERRUPT_CONTROL0_OUT <= `BYTE_ZERO;
          PROGCOUNT_LOW_BYTE_OUT <= `BYTE_ZERO;
          PWM_CH0_DUTY_LOW_OUT <= `PWM_LOW_ZERO;
          PWM_CH0_DUTY_HIGH_OUT <= `BYTE_ZERO;
          PWM_CH0_BASE_OUT <= `BYTE_ZERO;
          PORT_A_DATA_OUT <= `BYTE_ONES;
          PORT_A_DIRECTION_OUT <= `BYTE_ONES;
          PORT_B_DATA_OUT <= `BYTE_ONES;
          PORT_B_DIRECTION_OUT <= `BYTE_ONES;
          PORT_C_DATA_OUT <= `BYTE_ONES;
          PORT_C_DIRECTION_OUT <= `BYTE_ONES;
          PRESERVE_ACC_TABLE_OUT <= `ONE_BIT_SET;
        end
        default: begin
          // No request: presets stand
        end
      endcase
    end
  end

endmodule

// ==== hdl/startup_delay.v ====
// Start-up hold-off timer: counts after the reset request lifts.
// Assumes hold_in is high while a pin or supply reset request is active.
`timescale 1ns/1ns
`include "reset_ctrl_defs.vh"

module startup_delay (
  input wire clk_in, // System clock
  input wire rst_in, // Synchronous reset, active high
  input wire hold_in, // Reset still requested
  output reg run_out // High once delay has elapsed
);

  reg [`CNT_W-1:0] cnt_q; // Delay counter

  // ----------------------------------------
  // Delay counter
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (rst_in || hold_in) begin
      cnt_q <= `CNT_ZERO;
      run_out <= `ONE_BIT_CLR;
    end else if (cnt_q < `SST_CYCLES) begin
      cnt_q <= cnt_q + `CNT_ONE;
      run_out <= `ONE_BIT_CLR;
    end else begin
      run_out <= `ONE_BIT_SET;
    end
  end

endmodule

// ==== shared/reset_ctrl_defs.vh ====
// Constants for the reset source controller: widths, reset values, timing.
// Assumes a 100 MHz system clock; included by bare name from hdl files.
`ifndef RESET_CTRL_DEFS_VH
`define RESET_CTRL_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define LVQ_TIME_NS 1000
`define LVQ_CYCLES ((`LVQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SST_TIME_NS 10000
`define SST_CYCLES ((`SST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define THR_RST 2'h0
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hff
`define PWM_LOW_ZERO 6'h00
`define WATCHDOG_PRESCALE_SELECT_RST 3'h7
`define TIMER_CONTROL_RST 5'h01
`define FLAGS_CLEAR 2'h0
`define PC_ZERO 12'h000
`define SP_EMPTY 3'h0
`define ONE_BIT_SET 1'h1
`define ONE_BIT_CLR 1'h0
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001

// ----------------------------------------
// Reset cause codes
// ----------------------------------------
`define CAUSE_NONE 3'h0
`define CAUSE_POR 3'h1
`define CAUSE_PIN 3'h2
`define CAUSE_LVR 3'h3
`define CAUSE_WDT_RUN 3'h4
`define CAUSE_WDT_HALT 3'h5
`define CAUSE_USB_RUN 3'h6
`define CAUSE_USB_HALT 3'h7

`endif
